// ==== core/htec_trigger_ctrl.sv ====
`timescale 1ns/10ps
`include "htec_params.svh"
module htec_trigger_ctrl
  import htec_pkg::*;
#(
  parameter bit WIDTH_MODE_AVAILABLE = 1'b1
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [3:0]              inputLines,
  input  wire logic [`HTEC_LINE_W-1:0] triggerSourceSel,
  input  wire logic                    triggerModeOn,
  input  wire htec_edge_t              edgeSel,
  input  wire htec_exp_t               exposureMode,
  input  wire htec_acq_t               acquisitionMode,
  input  wire logic                    acqStartCmd,
  input  wire logic                    acqStopCmd,
  input  wire logic [`HTEC_RAW_W-1:0]  exposureDurationSetting,
  input  wire logic [`HTEC_BASE_W-1:0] timeBaseCycles,
  input  wire logic                    readoutBusy,
  output logic                         triggerReadyOut,
  output logic                         exposureActive,
  output logic                         readoutStart,
  output logic                         armed
);
  typedef enum logic [1:0] { ST_IDLE, ST_TIMED, ST_WIDTH, ST_HOLD } htec_st_t;

  htec_st_t                st_r;
  logic                    externalTriggerIn;
  logic                    trigSync;
  logic                    trigPrev_r;
  logic                    activeEdge;
  logic                    endEdge;
  logic                    accept;
  logic                    timerRun;
  logic                    timerDone;
  logic                    widthMode;
  logic                    readoutAtStart_r;
  logic [`HTEC_LINE_W-1:0] lineSel_r;

  // Latched source select; defaults to the first input line after reset
  always_ff @(posedge clk) begin // see [R4]
    if (rst) begin
      lineSel_r <= `HTEC_LINE_FIRST;
    end else begin
      lineSel_r <= triggerSourceSel;
    end
  end

  assign externalTriggerIn = inputLines[lineSel_r];

  htec_sync htec_sync_inst (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (externalTriggerIn),
    .syncOut (trigSync)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      trigPrev_r <= 1'b0;
    end else begin
      trigPrev_r <= trigSync;
    end
  end

  // Edge polarity follows the edge selection
  assign activeEdge = (edgeSel == HTEC_EDGE_RISE) ? // see [R1]
                      (trigSync & ~trigPrev_r) : (~trigSync & trigPrev_r);
  assign endEdge    = (edgeSel == HTEC_EDGE_RISE) ? // see [R8]
                      (~trigSync & trigPrev_r) : (trigSync & ~trigPrev_r);

  assign widthMode = WIDTH_MODE_AVAILABLE && // see [R9]
                     (exposureMode == HTEC_EXP_WIDTH);

  // One acquisition per accepted edge; unarmed edges fall away
  assign accept = armed && triggerModeOn && activeEdge && // see [R2] [R21]
                  (st_r == ST_IDLE);

  // Arming: start arms, stop disarms, single frame disarms on use
  always_ff @(posedge clk) begin // see [R15] [R17] [R19]
    if (rst) begin
      armed <= 1'b0;
    end else if (acqStopCmd) begin
      armed <= 1'b0;
    end else if (acqStartCmd) begin
      armed <= 1'b1;
    end else if (accept && acquisitionMode == HTEC_ACQ_SINGLE) begin
      armed <= 1'b0;
    end
  end

  // Timer runs in both modes; in width mode it only gates ready
  htec_exp_timer htec_exp_timer_inst ( // see [R7] [R10]
    .clk        (clk),
    .rst        (rst),
    .start      (accept),
    .rawValue   (exposureDurationSetting),
    .baseCycles (timeBaseCycles),
    .running    (timerRun),
    .done       (timerDone)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      readoutAtStart_r <= 1'b0;
    end else if (accept) begin
      readoutAtStart_r <= readoutBusy;
    end
  end

  // Exposure sequencing
  always_ff @(posedge clk) begin // see [R6]
    if (rst) begin
      st_r <= ST_IDLE;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (accept) begin
            st_r <= widthMode ? ST_WIDTH : ST_TIMED;
          end
        end
        ST_TIMED: begin
          if (timerDone) begin // see [R7]
            st_r <= ST_IDLE;
          end
        end
        ST_WIDTH: begin
          if (endEdge) begin // see [R8] [R12] [R13]
            st_r <= readoutBusy ? ST_HOLD : ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (!readoutBusy) begin // see [R12]
            st_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign exposureActive = (st_r != ST_IDLE);

  // Readout begins as exposure ends
  always_ff @(posedge clk) begin // see [R18]
    if (rst) begin
      readoutStart <= 1'b0;
    end else begin
      readoutStart <= exposureActive &&
                      ((st_r == ST_TIMED && timerDone) ||
                       (st_r == ST_WIDTH && endEdge && !readoutBusy) ||
                       (st_r == ST_HOLD && !readoutBusy));
    end
  end

  // Ready when armed, trigger mode on, idle, readout not busy and no minimum exposure still counting
  always_ff @(posedge clk) begin // see [R10] [R16]
    if (rst) begin
      triggerReadyOut <= 1'b0;
    end else begin
      triggerReadyOut <= armed && triggerModeOn && !accept &&
                         (st_r == ST_IDLE) && !timerRun && !readoutBusy;
    end
  end

  a_single_disarm: assert property ( // see [R17]
    @(posedge clk) disable iff (rst)
    accept && acquisitionMode == HTEC_ACQ_SINGLE && !acqStartCmd
    |=> !armed)
    else $error("single frame did not disarm");

  a_stop_disarm: assert property ( // see [R19]
    @(posedge clk) disable iff (rst)
    acqStopCmd |=> !armed)
    else $error("stop did not disarm");

  a_unarmed_ignore: assert property ( // see [R21]
    @(posedge clk) disable iff (rst)
    !armed && st_r == ST_IDLE |=> st_r == ST_IDLE)
    else $error("edge accepted while unarmed");

  a_edge_starts: assert property ( // see [R1]
    @(posedge clk) disable iff (rst)
    accept |=> exposureActive)
    else $error("accepted edge did not start exposure");

  a_timed_end: assert property ( // see [R7]
    @(posedge clk) disable iff (rst)
    st_r == ST_TIMED && timerDone |=> !exposureActive ##0 readoutStart)
    else $error("timed exposure did not end on timer");

  sequence s_widthEndBusy;
    st_r == ST_WIDTH && endEdge && readoutBusy;
  endsequence

  a_width_extend: assert property ( // see [R12]
    @(posedge clk) disable iff (rst)
    s_widthEndBusy |=> st_r == ST_HOLD)
    else $error("width exposure not extended during readout");

  a_width_normal: assert property ( // see [R13]
    @(posedge clk) disable iff (rst)
    st_r == ST_WIDTH && endEdge && !readoutBusy |=> !exposureActive)
    else $error("width exposure did not end on edge");

  a_width_hold: assert property ( // see [R8]
    @(posedge clk) disable iff (rst)
    st_r == ST_WIDTH && !endEdge |=> exposureActive)
    else $error("width exposure ended without edge");

  a_ready_idle: assert property ( // see [R16]
    @(posedge clk) disable iff (rst)
    triggerReadyOut |-> $past(armed) && $past(st_r == ST_IDLE))
    else $error("ready high while not idle");
endmodule : htec_trigger_ctrl

// ==== core/htec_params.svh ====
// Function
// [R1] Acquisition starts on rising or falling trigger edge, per edge setting.
// [R2] One acquisition per accepted active trigger edge.
// [R3] Source holds trigger active at least 100 ns after the edge.
// [R4] After reset the trigger comes from input line 1 unless selected.
// [R5] Source never triggers faster than the allowed maximum rate.
// [R6] Two exposure modes under external trigger: timed and pulse width.
// [R7] Timed mode exposes for programmed duration regardless of trigger.
// [R8] Pulse width mode ends exposure at the opposite trigger edge.
// [R9] Pulse width mode exists unless the variant parameter disables it.
// [R10] Pulse width mode still uses the duration setting to time ready.
// [R11] Host programs duration to the shortest intended pulse exposure.
// [R12] Pulse width exposure extends until previous readout completes.
// [R13] Ending edge after readout completes ends exposure normally.
// [R14] Host selects start trigger, mode on, line 1 and edge.
// [R15] Single frame start command arms for exactly one trigger.
// [R16] Source applies edges only while the ready output is high.
// [R17] After single frame trigger, further edges ignored until re-armed.
// [R18] Exposure end starts readout and transmission of the image.
// [R19] Continuous mode stops answering edges after a stop command.
// [R20] Timed duration is raw value 1 to 4095 times the time base.
// [R21] Trigger is synchronised first; edges while unarmed are discarded.
`ifndef HTEC_PARAMS_SVH
`define HTEC_PARAMS_SVH
`define HTEC_RAW_W        12
`define HTEC_RAW_MAX      12'hfff
`define HTEC_RAW_MIN      12'h001
`define HTEC_BASE_W       24
`define HTEC_BASE_RST     24'h000014
`define HTEC_CLK_MHZ      20
`define HTEC_MIN_PULSE_NS 100
`define HTEC_CLK_NS       50
`define HTEC_MIN_PULSE_CYC \
  ((`HTEC_MIN_PULSE_NS + `HTEC_CLK_NS - 1) / `HTEC_CLK_NS)
`define HTEC_LINE_W       2
`define HTEC_LINE_FIRST   2'h0
`endif

// ==== core/htec_pkg.sv ====
package htec_pkg;
  typedef enum logic { HTEC_EDGE_RISE, HTEC_EDGE_FALL } htec_edge_t;
  typedef enum logic { HTEC_EXP_TIMED, HTEC_EXP_WIDTH } htec_exp_t;
  typedef enum logic { HTEC_ACQ_SINGLE, HTEC_ACQ_CONT } htec_acq_t;
endpackage : htec_pkg

// ==== core/htec_sync.sv ====
`timescale 1ns/10ps
module htec_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Three stages; the level changes once the second and third agree
  always_ff @(posedge clk) begin // see [R21]
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= asyncIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      syncOut <= 1'b0;
    end else if (s2_r == s3_r) begin
      syncOut <= s3_r;
    end
  end
endmodule : htec_sync

// ==== core/htec_exp_timer.sv ====
`timescale 1ns/10ps
`include "htec_params.svh"
module htec_exp_timer (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    start,
  input  wire logic [`HTEC_RAW_W-1:0]  rawValue,
  input  wire logic [`HTEC_BASE_W-1:0] baseCycles,
  output logic                         running,
  output logic                         done
);
  logic [`HTEC_BASE_W-1:0] baseCnt_r;
  logic [`HTEC_RAW_W-1:0]  rawCnt_r;
  logic                    lastTick;

  assign lastTick = (baseCnt_r <= `HTEC_BASE_W'(1)) &&
                    (rawCnt_r <= `HTEC_RAW_W'(1));

  // Duration is raw count times base period, both clamped to one at least
  always_ff @(posedge clk) begin // see [R20]
    if (rst) begin
      running   <= 1'b0;
      done      <= 1'b0;
      baseCnt_r <= '0;
      rawCnt_r  <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        running   <= 1'b1;
        baseCnt_r <= baseCycles;
        rawCnt_r  <= (rawValue < `HTEC_RAW_MIN) ? `HTEC_RAW_MIN : rawValue;
      end else if (running) begin
        if (lastTick) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else if (baseCnt_r <= `HTEC_BASE_W'(1)) begin
          baseCnt_r <= baseCycles;
          rawCnt_r  <= rawCnt_r - `HTEC_RAW_W'(1);
        end else begin
          baseCnt_r <= baseCnt_r - `HTEC_BASE_W'(1);
        end
      end
    end
  end
endmodule : htec_exp_timer

// ==== tb/htec_trig_src.sv ====
`timescale 1ns/10ps
module htec_trig_src (
  input  wire logic       clk,
  input  wire logic       readyIn,
  input  wire logic       go,
  input  wire logic       ignoreReady,
  input  wire logic       activeLow,
  input  wire logic [1:0] lineIdx,
  input  wire logic [7:0] holdCyc,
  output logic      [3:0] lines
);
  logic [7:0] cnt_r  = 8'h00;
  logic       pend_r = 1'b0;
  always @(posedge clk) begin
    if (go) begin
      pend_r <= 1'b1;
    end
    if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end else if (pend_r && (readyIn || ignoreReady)) begin
      pend_r <= 1'b0;
      cnt_r  <= holdCyc;
    end
  end
  // Idle lines rest at the inactive level; they move on the falling edge
  always @(negedge clk) begin
    lines <= (cnt_r != 8'h00) ? ({4{activeLow}} ^ (4'h1 << lineIdx))
                              : {4{activeLow}};
  end
endmodule : htec_trig_src

// ==== tb/htec_trigger_ctrl_tb.sv ====
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
  badCount++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module htec_trigger_ctrl_tb import htec_pkg::*; ;
  logic clk = 1'b0, rst = 1'b1, triggerModeOn = 1'b1, readoutBusy = 1'b0;
  logic acqStartCmd = 1'b0, acqStopCmd = 1'b0, go = 1'b0, ign = 1'b0;
  logic activeLow = 1'b0;
  logic [1:0] triggerSourceSel = 2'h0, lineIdx = 2'h0;
  logic [7:0] holdCyc = 8'h02;
  logic [3:0] inputLines;
  htec_edge_t edgeSel = HTEC_EDGE_RISE;
  htec_exp_t exposureMode = HTEC_EXP_TIMED;
  htec_acq_t acquisitionMode = HTEC_ACQ_SINGLE;
  logic triggerReadyOut, exposureActive, readoutStart, armed;
  int badCount = 0, comparisons = 0, n, r;
  htec_trigger_ctrl #(.WIDTH_MODE_AVAILABLE(1'b1)) htec_trigger_ctrl_inst (
    .clk(clk), .rst(rst), .inputLines(inputLines),
    .triggerSourceSel(triggerSourceSel), .triggerModeOn(triggerModeOn),
    .edgeSel(edgeSel), .exposureMode(exposureMode),
    .acquisitionMode(acquisitionMode), .acqStartCmd(acqStartCmd),
    .acqStopCmd(acqStopCmd), .exposureDurationSetting(12'h003),
    .timeBaseCycles(24'h000002), .readoutBusy(readoutBusy),
    .triggerReadyOut(triggerReadyOut), .exposureActive(exposureActive),
    .readoutStart(readoutStart), .armed(armed));
  htec_trig_src htec_trig_src_inst (
    .clk(clk), .readyIn(triggerReadyOut), .go(go), .ignoreReady(ign),
    .activeLow(activeLow), .lineIdx(lineIdx), .holdCyc(holdCyc),
    .lines(inputLines));
  initial begin
    forever #25 clk = ~clk;
  end
  task endOfTest;
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : endOfTest
  task cmd(input logic stop);
    @(negedge clk);
    acqStartCmd = ~stop;
    acqStopCmd  = stop;
    @(negedge clk);
    acqStartCmd = 1'b0;
    acqStopCmd  = 1'b0;
    @(negedge clk);
  endtask : cmd
  // One trigger request; counts exposure cycles and readout pulses
  task fire(input logic [7:0] hold, input logic ig, input int busyDrop);
    @(negedge clk);
    go = 1'b1;
    ign = ig;
    holdCyc = hold;
    @(negedge clk);
    go = 1'b0;
    n = 0;
    r = 0;
    for (int i = 0; i < 150; i++) begin
      @(negedge clk);
      if (i == busyDrop) readoutBusy = 1'b0;
      if (exposureActive === 1'b1) n++;
      if (readoutStart === 1'b1) r++;
    end
    ign = 1'b0;
  endtask : fire
  task s_single(input logic e);
    edgeSel = htec_edge_t'(e);
    activeLow = e;
    exposureMode = HTEC_EXP_TIMED;
    acquisitionMode = HTEC_ACQ_SINGLE;
    cmd(1'b0);
    `CHK("armed", 1'b1, armed)
    `CHK("ready", 1'b1, triggerReadyOut)
    fire(8'h02, 1'b0, 999);
    `CHK("timedLen", 1'b1, n >= 6 && n <= 7)
    `CHK("readout", 1'b1, r == 1)
    `CHK("disarmed", 1'b0, armed)
    fire(8'h02, 1'b1, 999);
    `CHK("ignored", 1'b1, n == 0 && r == 0)
  endtask : s_single
  task s_width;
    edgeSel = HTEC_EDGE_RISE;
    activeLow = 1'b0;
    exposureMode = HTEC_EXP_WIDTH;
    cmd(1'b0);
    fire(8'h14, 1'b0, 999);
    `CHK("widthLen", 1'b1, n >= 18 && n <= 22)
    readoutBusy = 1'b1;
    cmd(1'b0);
    fire(8'h0a, 1'b1, 30);
    `CHK("extended", 1'b1, n >= 20 && n <= 30)
    readoutBusy = 1'b1;
    cmd(1'b0);
    fire(8'h14, 1'b1, 8);
    `CHK("normalEnd", 1'b1, n >= 18 && n <= 22)
  endtask : s_width
  task s_cont;
    exposureMode = HTEC_EXP_TIMED;
    acquisitionMode = HTEC_ACQ_CONT;
    cmd(1'b0);
    fire(8'h02, 1'b0, 999);
    `CHK("first", 1'b1, r == 1)
    fire(8'h02, 1'b0, 999);
    `CHK("second", 1'b1, r == 1 && armed === 1'b1)
    triggerSourceSel = 2'h1;
    fire(8'h02, 1'b1, 999);
    `CHK("otherLine", 1'b1, r == 0)
    lineIdx = 2'h1;
    fire(8'h02, 1'b0, 999);
    `CHK("selLine", 1'b1, r == 1)
    cmd(1'b1);
    `CHK("stopped", 1'b0, armed)
    fire(8'h02, 1'b1, 999);
    `CHK("afterStop", 1'b1, n == 0 && r == 0)
  endtask : s_cont
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    `CHK("rstArmed", 1'b0, armed)
    `CHK("rstReady", 1'b0, triggerReadyOut)
    s_single(1'b0);
    s_single(1'b1);
    s_width();
    s_cont();
    endOfTest();
  end
  initial begin
    repeat (6000) @(posedge clk);
    badCount++;
    endOfTest();
  end
endmodule : htec_trigger_ctrl_tb
